// >>> rtl/apws_top.sv
// How it works
// - two 8-bit software wait registers, read/write
// - on-chip and internal I/O never waited
// - power-on reset, hardware standby load all ones
// - manual reset, software standby keep contents
// - field value equals inserted wait count
// - waits only external, access-state bit set
// - upper register holds areas 7 down to 4
// - lower register holds areas 3 down to 0
// - access-state bit zero: two-state, no waits
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "apws_regs.svh"

module apws_top
  import apws_pkg::*;
(
  // clock and power-on reset
  input wire logic clk,
  input wire logic reset_n,
  // asynchronous mode pins
  input wire logic hw_standby_n,
  input wire logic manual_reset_n,
  input wire logic soft_standby,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // internal bus master request
  input wire logic req_valid,
  input wire logic [2:0] req_area,
  input wire logic req_external,
  input wire logic [23:0] req_addr,
  output logic req_done,
  // external bus pins
  output logic [23:0] ext_addr,
  output logic [7:0] ext_cs_n,
  output logic ext_strobe_n
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] pin_meta_r; // first stage, read only by second stage
  logic [2:0] pin_sync_r; // safe copies
  logic hw_standby_s; // active high after sync
  logic manual_rst_s; // active high after sync
  logic soft_stby_s;

  // two flops per pin, the pins are not timed to clk
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pin_meta_r <= 3'h3;
      pin_sync_r <= 3'h3;
    end
    else
    begin
      pin_meta_r <= {soft_standby, manual_reset_n, hw_standby_n};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign hw_standby_s = !pin_sync_r[0];
  assign manual_rst_s = !pin_sync_r[1];
  assign soft_stby_s = pin_sync_r[2];

  // ****************************************************************
  // avalon slave handshake
  // ****************************************************************
  logic resp_r; // answer cycle marker
  logic bus_req;
  logic wr_take; // write commits at this edge
  logic [7:0] wait_upper_r;
  logic [7:0] wait_lower_r;
  logic [7:0] ast_r; // access_state_control_reg
  logic [7:0] status;
  logic [31:0] rdata_r;

  assign bus_req = avs_read || avs_write;
  // one wait cycle: readdata is already in its flop when released
  assign avs_waitrequest = bus_req && !resp_r;
  assign wr_take = avs_write && resp_r;
  assign avs_readdata = rdata_r;

  // answer marker is high for one cycle per request
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      resp_r <= 1'b0;
    else
      resp_r <= bus_req && !resp_r;
  end

  // read mux, unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rdata_r <= 32'h0;
    else if (avs_read && !resp_r)
    begin
      case (avs_address)
        `APWS_OFS_WAIT_UPPER: rdata_r <= {24'h0, wait_upper_r};
        `APWS_OFS_WAIT_LOWER: rdata_r <= {24'h0, wait_lower_r};
        `APWS_OFS_ACCESS_STATE: rdata_r <= {24'h0, ast_r};
        `APWS_OFS_STATUS: rdata_r <= {24'h0, status};
        default: rdata_r <= 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // wait and access-state registers
  // ****************************************************************
  // manual reset and software standby are deliberately not listed here
  always_ff @(posedge clk)
  begin
    if (!reset_n || hw_standby_s)
    begin
      wait_upper_r <= `APWS_RESET_WAIT;
      wait_lower_r <= `APWS_RESET_WAIT;
      ast_r <= `APWS_RESET_ACCESS_STATE;
    end
    else if (wr_take)
    begin
      case (avs_address)
        `APWS_OFS_WAIT_UPPER: wait_upper_r <= avs_writedata[7:0];
        `APWS_OFS_WAIT_LOWER: wait_lower_r <= avs_writedata[7:0];
        `APWS_OFS_ACCESS_STATE: ast_r <= avs_writedata[7:0];
        default: ; // status is read only, other writes dropped
      endcase
    end
  end

  // per-area field split
  apws_wait_t area_wait [`APWS_AREAS];
  genvar gi;
  generate
    for (gi = 0; gi < `APWS_AREAS; gi++)
    begin : g_area
      if (gi < 4)
      begin : g_lo
        assign area_wait[gi] = wait_lower_r[2*gi+1 -: 2];
      end
      else
      begin : g_hi
        assign area_wait[gi] = wait_upper_r[2*(gi-4)+1 -: 2];
      end
    end
  endgenerate

  // ****************************************************************
  // external cycle sequencer
  // ****************************************************************
  apws_state_e state_r;
  apws_state_e state_nxt;
  logic seq_clr; // sequencer reset, manual reset included
  logic accept;
  logic three_r; // 3-state cycle with waits armed
  logic [2:0] area_r;
  apws_wait_t sel_r; // field captured at accept
  apws_wait_t cnt;
  logic cnt_last;

  assign seq_clr = !reset_n || hw_standby_s || manual_rst_s;
  // software standby stalls new cycles; a running one finishes
  assign accept = (state_r == APWS_IDLE) && req_valid && !soft_stby_s;

  // next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      APWS_IDLE:
        if (accept)
          state_nxt = req_external ? APWS_T1 : APWS_INT;
      APWS_INT: state_nxt = APWS_IDLE;
      APWS_T1: state_nxt = APWS_T2;
      APWS_T2:
        if (!three_r)
          state_nxt = APWS_IDLE;
        else if (sel_r != 2'h0)
          state_nxt = APWS_TW;
        else
          state_nxt = APWS_T3;
      APWS_TW:
        if (cnt_last)
          state_nxt = APWS_T3;
      APWS_T3: state_nxt = APWS_IDLE;
      default: state_nxt = APWS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (seq_clr)
      state_r <= APWS_IDLE;
    else
      state_r <= state_nxt;
  end

  // capture of the request attributes
  always_ff @(posedge clk)
  begin
    if (seq_clr)
    begin
      three_r <= 1'b0;
      area_r <= 3'h0;
      sel_r <= 2'h0;
    end
    else if (accept)
    begin
      three_r <= req_external && ast_r[req_area];
      area_r <= req_area;
      sel_r <= area_wait[req_area];
    end
  end

  // wait counter, loaded with the area field
  apws_wait_count u_cnt (
    .clk(clk),
    .clr(seq_clr),
    .load(accept),
    .load_val(area_wait[req_area]),
    .tick(state_r == APWS_TW),
    .count(cnt),
    .last(cnt_last)
  );

  // completion pulse back to the internal master
  assign req_done = (state_r == APWS_INT) || (state_r == APWS_T3) ||
    (state_r == APWS_T2 && !three_r);

  // ****************************************************************
  // external pins
  // ****************************************************************
  // outputs follow the next state so they are glitch free flops
  always_ff @(posedge clk)
  begin
    if (seq_clr)
    begin
      ext_addr <= 24'h0;
      ext_cs_n <= 8'hff;
      ext_strobe_n <= 1'b1;
    end
    else
    begin
      if (accept && req_external)
        ext_addr <= req_addr; // held through waits
      if (state_nxt == APWS_T1 || state_nxt == APWS_T2 ||
          state_nxt == APWS_TW || state_nxt == APWS_T3)
        ext_cs_n <= ~(8'h01 << (accept ? req_area : area_r));
      else
        ext_cs_n <= 8'hff;
      ext_strobe_n <= !(state_nxt == APWS_T2 || state_nxt == APWS_TW ||
        state_nxt == APWS_T3);
    end
  end

  // status view of the sequencer
  always_comb
  begin
    status = 8'h0;
    status[`APWS_STAT_BUSY] = (state_r != APWS_IDLE);
    status[`APWS_STAT_AREA_LO +: 3] = area_r;
    status[`APWS_STAT_CNT_LO +: 2] = cnt;
    status[`APWS_STAT_THREE] = three_r;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic [2:0] tw_seen_r; // wait states spent in this cycle

  always_ff @(posedge clk)
  begin
    if (seq_clr || accept)
      tw_seen_r <= 3'h0;
    else if (state_r == APWS_TW)
      tw_seen_r <= tw_seen_r + 3'h1;
  end

  property p_w_commit;
    @(posedge clk) disable iff (!reset_n)
    wr_take && avs_address == `APWS_OFS_WAIT_LOWER && !hw_standby_s
    |=> wait_lower_r == $past(avs_writedata[7:0]);
  endproperty
  a_w_commit: assert property (p_w_commit)
    else $error("lower wait register missed a write");

  property p_int_nowait;
    @(posedge clk) disable iff (seq_clr)
    accept && !req_external |=> state_r == APWS_INT ##1
      state_r == APWS_IDLE;
  endproperty
  a_int_nowait: assert property (p_int_nowait)
    else $error("internal access took wait states");

  property p_reset_ones;
    @(posedge clk)
    !reset_n || hw_standby_s |=> wait_upper_r == 8'hff &&
      wait_lower_r == 8'hff;
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("wait registers not all ones after reset");

  property p_keep;
    @(posedge clk) disable iff (!reset_n || hw_standby_s)
    (manual_rst_s || soft_stby_s) && !wr_take |=>
      $stable(wait_upper_r) && $stable(wait_lower_r);
  endproperty
  a_keep: assert property (p_keep)
    else $error("wait registers lost contents in standby");

  property p_count;
    @(posedge clk) disable iff (seq_clr)
    state_r == APWS_T3 |-> tw_seen_r == {1'b0, sel_r};
  endproperty
  a_count: assert property (p_count)
    else $error("wait states differ from the field value");

  property p_two_state;
    @(posedge clk) disable iff (seq_clr)
    accept && req_external && !ast_r[req_area] |=>
      state_r == APWS_T1 ##1 state_r == APWS_T2 && req_done
      ##1 state_r == APWS_IDLE;
  endproperty
  a_two_state: assert property (p_two_state)
    else $error("two-state area did not end after two states");

  property p_only_armed;
    @(posedge clk) disable iff (seq_clr)
    state_r == APWS_TW |-> three_r;
  endproperty
  a_only_armed: assert property (p_only_armed)
    else $error("wait inserted on an unarmed cycle");

  property p_upper_map;
    @(posedge clk) disable iff (seq_clr)
    accept && req_area == 3'h7 |=> sel_r == $past(wait_upper_r[7:6]);
  endproperty
  a_upper_map: assert property (p_upper_map)
    else $error("area 7 field taken from wrong bits");

  property p_lower_map;
    @(posedge clk) disable iff (seq_clr)
    accept && req_area == 3'h0 |=> sel_r == $past(wait_lower_r[1:0]);
  endproperty
  a_lower_map: assert property (p_lower_map)
    else $error("area 0 field taken from wrong bits");

  property p_hold;
    @(posedge clk) disable iff (seq_clr)
    state_r == APWS_TW |-> !ext_strobe_n && $stable(ext_addr) &&
      $stable(ext_cs_n);
  endproperty
  a_hold: assert property (p_hold)
    else $error("strobe or address moved during a wait state");

  c_three_waits: cover property (@(posedge clk) disable iff (seq_clr)
    state_r == APWS_T3 && tw_seen_r == 3'h3);
  c_no_wait_three: cover property (@(posedge clk) disable iff (seq_clr)
    state_r == APWS_T3 && tw_seen_r == 3'h0);
  c_two_state: cover property (@(posedge clk) disable iff (seq_clr)
    state_r == APWS_T2 && !three_r);
  c_internal: cover property (@(posedge clk) disable iff (seq_clr)
    state_r == APWS_INT);

endmodule

`default_nettype wire

// >>> pkg/apws_regs.svh
`ifndef APWS_REGS_SVH
`define APWS_REGS_SVH

// ****************************************************************
// register map (byte addresses on the avalon slave)
// ****************************************************************
`define APWS_OFS_WAIT_UPPER 4'h0
`define APWS_OFS_WAIT_LOWER 4'h4
`define APWS_OFS_ACCESS_STATE 4'h8
`define APWS_OFS_STATUS 4'hc

// ****************************************************************
// reset values and field layout
// ****************************************************************
`define APWS_RESET_WAIT 8'hff
`define APWS_RESET_ACCESS_STATE 8'hff
`define APWS_FIELD_W 2
`define APWS_AREAS 8
`define APWS_STAT_BUSY 0
`define APWS_STAT_AREA_LO 1
`define APWS_STAT_CNT_LO 4
`define APWS_STAT_THREE 6

`endif

// >>> pkg/apws_pkg.sv
`default_nettype none

package apws_pkg;

  // external bus cycle sequence
  typedef enum logic [2:0] {
    APWS_IDLE,
    APWS_INT,
    APWS_T1,
    APWS_T2,
    APWS_TW,
    APWS_T3
  } apws_state_e;

  // one program wait field
  typedef logic [1:0] apws_wait_t;

endpackage

`default_nettype wire

// >>> rtl/apws_wait_count.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// program wait down-counter
// ****************************************************************
module apws_wait_count
  import apws_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic clr,
  // control
  input wire logic load,
  input wire apws_wait_t load_val,
  input wire logic tick,
  // state
  output apws_wait_t count,
  output logic last
);

  apws_wait_t count_r; // remaining wait states

  // load wins over tick so a new cycle never inherits a stale count
  always_ff @(posedge clk)
  begin
    if (clr)
      count_r <= 2'h0;
    else if (load)
      count_r <= load_val;
    else if (tick && count_r != 2'h0)
      count_r <= count_r - 2'h1;
  end

  assign count = count_r;
  assign last = (count_r == 2'h1);

endmodule

`default_nettype wire

// >>> sim/apws_ext_mem.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// passive model of the area-decoded external devices
// ****************************************************************
module apws_ext_mem
(
  // clock
  input wire logic clk,
  // external bus pins
  input wire logic [23:0] ext_addr,
  input wire logic [7:0] ext_cs_n,
  input wire logic ext_strobe_n,
  // frame log for the bench
  output int frames,
  output int last_cs_cycles,
  output int last_strobe_cycles,
  output logic [7:0] last_cs_n,
  output logic [23:0] last_addr,
  output int addr_moves
);
  int cs_cnt; // select-low cycles in the current frame
  int st_cnt; // strobe-low cycles in the current frame

  initial
  begin
    {frames, last_cs_cycles, last_strobe_cycles, addr_moves} = '0;
    {cs_cnt, st_cnt, last_cs_n, last_addr} = '0;
  end

  // a device sees only its select; frame length shows the waits
  always @(posedge clk)
  begin
    if (ext_cs_n !== 8'hff)
    begin
      if (cs_cnt == 0)
        last_addr <= ext_addr;
      else if (ext_addr !== last_addr)
        addr_moves <= addr_moves + 1;
      last_cs_n <= ext_cs_n;
      cs_cnt <= cs_cnt + 1;
      st_cnt <= st_cnt + ((ext_strobe_n === 1'b0) ? 1 : 0);
    end
    // frame ends when every select has returned high
    else if (cs_cnt != 0)
    begin
      frames <= frames + 1;
      last_cs_cycles <= cs_cnt;
      last_strobe_cycles <= st_cnt;
      cs_cnt <= 0;
      st_cnt <= 0;
    end
  end
endmodule

`default_nettype wire

// >>> sim/apws_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "apws_regs.svh"

module apws_bench
  import apws_pkg::*;
  ;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk = 0;
  logic reset_n = 0;
  logic hw_standby_n = 1;
  logic manual_reset_n = 1;
  logic soft_standby = 0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic req_valid = 0;
  logic [2:0] req_area = 3'h0;
  logic req_external = 0;
  logic [23:0] req_addr = 24'h0;
  logic req_done;
  logic [23:0] ext_addr;
  logic [7:0] ext_cs_n;
  logic ext_strobe_n;
  int frames, cs_cyc, st_cyc, addr_moves;
  logic [7:0] seen_cs_n;
  logic [23:0] seen_addr;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] up_m = 8'hff; // expected upper register
  logic [7:0] lo_m = 8'hff; // expected lower register
  logic [7:0] ast_m = 8'hff; // expected access-state register

  apws_top dut_u (.clk(clk), .reset_n(reset_n),
    .hw_standby_n(hw_standby_n), .manual_reset_n(manual_reset_n),
    .soft_standby(soft_standby), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
    .req_area(req_area), .req_external(req_external),
    .req_addr(req_addr), .req_done(req_done), .ext_addr(ext_addr),
    .ext_cs_n(ext_cs_n), .ext_strobe_n(ext_strobe_n));

  apws_ext_mem mem_u (.clk(clk), .ext_addr(ext_addr),
    .ext_cs_n(ext_cs_n), .ext_strobe_n(ext_strobe_n), .frames(frames),
    .last_cs_cycles(cs_cyc), .last_strobe_cycles(st_cyc),
    .last_cs_n(seen_cs_n), .last_addr(seen_addr),
    .addr_moves(addr_moves));

  // ****************************************************************
  // clock, watchdog and report
  // ****************************************************************
  initial
  begin
    forever #10 clk = ~clk;
  end

  // a hung handshake must still reach the verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ****************************************************************
  // avalon master: hold until waitrequest low, take data there
  // ****************************************************************
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    // values read here are those that stood just before each edge
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    // the closing edge: take the data, then release
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check("readdata", {24'h0, e}, q);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // ****************************************************************
  // one internal master access, length from the expected registers
  // ****************************************************************
  task automatic acc(input logic [2:0] area, input logic ext);
    int n;
    int lat;
    int f0;
    apws_wait_t fld;
    f0 = frames;
    n = 0;
    fld = area[2] ? up_m[area[1:0] * 2 +: 2] : lo_m[area[1:0] * 2 +: 2];
    lat = !ext ? 1 : (!ast_m[area] ? 2 : 3 + fld);
    @(posedge clk);
    req_valid <= 1'b1;
    req_area <= area;
    req_external <= ext;
    req_addr <= {area, 21'h15a5a};
    @(negedge clk);
    while (req_done !== 1'b1)
    begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge clk);
    check("latency", lat, n);
    check("frames", f0 + ext, frames);
    if (ext)
    begin
      check("cs_n", {24'h0, ~(8'h01 << area)}, seen_cs_n);
      check("cs cycles", lat, cs_cyc);
      check("strobe cycles", lat - 1, st_cyc);
      check("addr", {area, 21'h15a5a}, seen_addr);
    end
  endtask

  task automatic rd_all();
    rd(`APWS_OFS_WAIT_UPPER, up_m);
    rd(`APWS_OFS_WAIT_LOWER, lo_m);
    rd(`APWS_OFS_ACCESS_STATE, ast_m);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    int f0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd_all();
    rd(4'h2, 8'h00);
    wr(4'h2, 8'h55);
    rd(4'h2, 8'h00);
    for (int a = 0; a < 8; a++)
      acc(3'(a), 1'b1);
    up_m = 8'he4;
    lo_m = 8'h1b;
    wr(`APWS_OFS_WAIT_UPPER, up_m);
    wr(`APWS_OFS_WAIT_LOWER, lo_m);
    rd_all();
    for (int a = 0; a < 8; a++)
    begin
      acc(3'(a), 1'b1);
      acc(3'(a), 1'b0);
    end
    ast_m = 8'h5a;
    wr(`APWS_OFS_ACCESS_STATE, ast_m);
    for (int a = 0; a < 8; a++)
      acc(3'(a), 1'b1);
    // manual reset keeps the registers
    manual_reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    manual_reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd_all();
    // software standby holds off a waiting request
    soft_standby <= 1'b1;
    repeat (5) @(posedge clk);
    f0 = frames;
    req_valid <= 1'b1;
    req_area <= 3'h3;
    req_external <= 1'b1;
    repeat (8) @(posedge clk);
    check("standby frames", f0, frames);
    soft_standby <= 1'b0;
    @(negedge clk);
    while (req_done !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    rd_all();
    // hardware standby reloads all ones
    hw_standby_n <= 1'b0;
    repeat (5) @(posedge clk);
    hw_standby_n <= 1'b1;
    repeat (5) @(posedge clk);
    {up_m, lo_m, ast_m} = {3{8'hff}};
    rd_all();
    acc(3'h4, 1'b1);
    // status after that cycle: idle, area 4, no waits left, armed
    rd(`APWS_OFS_STATUS, 8'h48);
    // power-on reset in mid-run
    wr(`APWS_OFS_WAIT_LOWER, 8'h00);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd_all();
    acc(3'h0, 1'b1);
    check("addr moves", 0, addr_moves);
    final_report();
  end
endmodule

`default_nettype wire
